// ---- common/ssd_pkg.sv ----
// package for the subtract instruction datapath
// Behaviour
// - register-form subtract computes register minus accumulator, 8-bit two's complement
// - destination bit 0 writes result to accumulator, register unchanged
// - destination bit 1 writes result back to the source register
// - bank bit 0 with extended set off addresses the fast access bank
// - bank bit 1 combines operand with bank selector to pick the bank
// - extended set on, bank bit 0, operand up to 5Fh uses indexed offset
package ssd_pkg;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 12;
    localparam int BANK_W       = 4;
    localparam logic [7:0] IDX_LIMIT    = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH  = 4'hF;
    localparam logic [7:0] ACC_RESET    = 8'h00;
    localparam logic [4:0] FLAGS_RESET  = 5'h00;
    localparam int FLAG_C  = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N  = 4;

    typedef enum logic [1:0] {SSD_OP_NONE, SSD_OP_LIT, SSD_OP_FILE} ssd_op_type;

    typedef struct packed {
        ssd_op_type  op;
        logic [7:0]  operand;
        logic        dest_sel;
        logic        bank_sel;
    } ssd_instr_type;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
        logic        en;
    } ssd_wr_type;
endpackage

// ---- tb/ssd_core_chk.sv ----
// port assertions for the subtract datapath
module ssd_core_chk
    import ssd_pkg::*;
(
    input wire logic          clk,
    input wire logic          rstn,
    input wire ssd_instr_type instr,
    input wire logic          ext_set_en,
    input wire logic [3:0]    bank_selector,
    input wire logic [11:0]   index_base,
    input wire logic [7:0]    file_rd_data,
    input wire logic [11:0]   file_rd_addr,
    input wire ssd_wr_type    file_wr_r,
    input wire logic [7:0]    acc_r,
    input wire logic [4:0]    flags_r,
    input wire logic          done_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire       fo = instr.op == SSD_OP_FILE;
    wire [7:0] k  = instr.operand;
    a_acc_dest: assert property (fo && !instr.dest_sel |=> !file_wr_r.en &&
        acc_r == 8'($past(file_rd_data) - $past(acc_r))) else $error("bad acc");
    a_reg_dest: assert property (fo && instr.dest_sel |=> file_wr_r.en &&
        $stable(acc_r) && file_wr_r.addr == $past(file_rd_addr)) else $error("bad wb");
    a_fast_bank: assert property (fo && !instr.bank_sel && !ext_set_en |->
        file_rd_addr == {k < 8'h60 ? 4'h0 : 4'hF, k}) else $error("bad fast");
    a_bank_pick: assert property (fo && instr.bank_sel |->
        file_rd_addr == {bank_selector, k}) else $error("bad bank");
    a_idx_off: assert property (fo && !instr.bank_sel && ext_set_en && k <= 8'h5F |->
        file_rd_addr == index_base + 12'(k)) else $error("bad index");
    a_done_once: assert property (instr.op != SSD_OP_NONE |=> done_r)
        else $error("no done");
    a_lit_flags: assert property (instr.op == SSD_OP_LIT |=>
        flags_r[FLAG_C] == ($past(k) >= $past(acc_r)) && acc_r == 8'($past(k) - $past(acc_r)))
        else $error("bad lit");
    a_wb_data: assert property (fo && instr.dest_sel |=>
        file_wr_r.data == 8'($past(file_rd_data) - $past(acc_r)))
        else $error("bad wb data");
    a_idle_quiet: assert property (instr.op == SSD_OP_NONE |=>
        !done_r && !file_wr_r.en && $stable(acc_r) && $stable(flags_r))
        else $error("idle moved");
    a_file_flags: assert property (fo |=>
        flags_r[FLAG_C] == ($past(file_rd_data) >= $past(acc_r)) &&
        flags_r[FLAG_Z] == ($past(file_rd_data) == $past(acc_r)))
        else $error("bad file flags");
    c_wb: cover property (fo && instr.dest_sel);
    c_idx: cover property (fo && ext_set_en && !instr.bank_sel && k <= 8'h5F);
    c_lit: cover property (instr.op == SSD_OP_LIT ##1 instr.op == SSD_OP_LIT);
endmodule
bind ssd_core ssd_core_chk u_chk (.*);

// ---- tb/ssd_core_tb.sv ----
// random self-checking bench for the subtract datapath
module ssd_core_tb
    import ssd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, ext = 0, done, pwr;
    logic [3:0] bsel = 4'h0;
    logic [11:0] base = 12'h000, ra, pa;
    logic [7:0] rd = 8'h00, acc, ea;
    logic [4:0] flg, ef;
    logic [12:0] r;
    logic [31:0] s;
    ssd_instr_type ins = '0;
    ssd_wr_type wr;
    ssd_op_type pop;
    int failures = 0, compares = 0;
    initial forever #2.5 clk = ~clk;
    ssd_core dut (.clk(clk), .rstn(rstn), .instr(ins), .ext_set_en(ext), .bank_selector(bsel),
        .index_base(base), .file_rd_data(rd), .file_rd_addr(ra), .file_wr_r(wr),
        .acc_r(acc), .flags_r(flg), .done_r(done));
    function automatic logic [31:0] lf(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // result with flags {N,OV,Z,DC,C} on top; carry means no borrow
    function automatic logic [12:0] ev(logic [7:0] m, logic [7:0] x);
        logic [7:0] d;
        d = m - x;
        return {d[7], m[7] != x[7] && d[7] != m[7], d == 8'h00, m[3:0] >= x[3:0], m >= x, d};
    endfunction
    // expected data address of an operand, from the addressing rules
    function automatic logic [11:0] xa(ssd_instr_type n, logic x, logic [3:0] b,
                                       logic [11:0] p);
        if (n.bank_sel) return {b, n.operand};
        if (x && n.operand <= IDX_LIMIT) return 12'(p + {4'h0, n.operand});
        return {n.operand < ACCESS_SPLIT ? 4'h0 : ACCESS_HIGH, n.operand};
    endfunction
    task automatic cmp(logic [11:0] g, logic [11:0] e);
        compares++;
        failures += int'(g !== e);
        if (g !== e) $display("[ERR] %0t %h %h", $time, g, e);
    endtask
    task give_verdict;
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial
    begin
        {s, ea, ef} = {32'hF8FAA0AC, 8'h00, 5'h00};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge clk);
            r = ev(ins.op == SSD_OP_LIT ? ins.operand : rd, ea);
            pa = xa(ins, ext, bsel, base);
            pop = ins.op;
            pwr = pop == SSD_OP_FILE && ins.dest_sel;
            if (pop != SSD_OP_NONE) ef = r[12:8];
            if (pop != SSD_OP_NONE && !pwr) ea = r[7:0];
            s = lf(s);
            // every fifth op sits on the 5Fh/60h offset boundary
            ins <= '{ssd_op_type'(s[1] ? 2'h2 : s[1:0]),
                i % 5 == 0 ? 8'h5F + 8'(i[3]) : s[9:2], s[10], s[11]};
            {ext, bsel, base, rd} <= {s[12], s[16:13], s[28:17], s[31:24]};
            #1;
            cmp(12'(done), 12'(pop != SSD_OP_NONE));
            cmp(12'(acc), 12'(ea));
            cmp(12'(flg), 12'(ef));
            cmp(12'(wr.en), 12'(pwr));
            if (pwr) cmp(12'(wr.data), 12'(r[7:0]));
            if (pwr) cmp(wr.addr, pa);
            cmp(ra, xa(ins, ext, bsel, base));
        end
        give_verdict;
    end
endmodule

// ---- verilog/ssd_alu.sv ----
// 8-bit subtractor producing result and status flags
module ssd_alu
    import ssd_pkg::*;
(
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    output logic [7:0]      diff,
    output logic [4:0]      flags
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb
    begin
        // carry set means no borrow
        full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff = full[7:0];
        flags = 5'h00;
        flags[FLAG_C]  = full[8];
        flags[FLAG_DC] = low[4];
        flags[FLAG_Z]  = (full[7:0] == 8'h00);
        flags[FLAG_N]  = full[7];
        flags[FLAG_OV] = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
    end
endmodule

// ---- verilog/ssd_core.sv ----
// subtract datapath: operand routing, subtract and writeback
module ssd_core
    import ssd_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire ssd_instr_type instr,
    input  wire logic          ext_set_en,
    input  wire logic [3:0]    bank_selector,
    input  wire logic [11:0]   index_base,
    input  wire logic [7:0]    file_rd_data,
    output logic [11:0]        file_rd_addr,
    output ssd_wr_type         file_wr_r,
    output logic [7:0]         acc_r,
    output logic [4:0]         flags_r,
    output logic               done_r
);
    // how the register operand becomes a data memory address
    typedef enum logic [1:0] {
        SSD_AM_BANK,
        SSD_AM_INDEX,
        SSD_AM_ACCESS
    } ssd_amode_type;

    // decode of the instruction on the bus this cycle
    logic          is_lit;
    logic          is_file;
    logic          to_acc;
    logic          to_reg;
    ssd_amode_type amode;
    logic [11:0]   addr;
    logic [7:0]    minuend;
    logic [7:0]    diff;
    logic [4:0]    flags;

    // next values, one group per register
    logic [7:0]    acc_nxt;
    logic [4:0]    flags_nxt;
    ssd_wr_type    file_wr_nxt;
    logic          done_nxt;

    // any opcode that the datapath executes; code 3 is never issued
    function automatic logic op_runs(input ssd_op_type op);
        op_runs = (op == SSD_OP_LIT) || (op == SSD_OP_FILE);
    endfunction

    // result lands in the accumulator: literal form, or register form with dest 0
    function automatic logic op_to_acc(input ssd_op_type op, input logic d);
        op_to_acc = (op == SSD_OP_LIT) || ((op == SSD_OP_FILE) && !d);
    endfunction

    // bank bit wins over the extended set; indexing covers only the low window
    function automatic ssd_amode_type addr_mode(input logic [7:0] f, input logic a,
                                                input logic ext);
        if (a)
        begin
            addr_mode = SSD_AM_BANK;
        end
        else if (ext && (f <= IDX_LIMIT))
        begin
            addr_mode = SSD_AM_INDEX;
        end
        else
        begin
            addr_mode = SSD_AM_ACCESS;
        end
    endfunction

    // access bank: low part at the bottom of memory, high part in the top page
    function automatic logic [11:0] access_addr(input logic [7:0] f);
        if (f < ACCESS_SPLIT)
        begin
            access_addr = {4'h0, f};
        end
        else
        begin
            access_addr = {ACCESS_HIGH, f};
        end
    endfunction

    // one subtractor serves both forms
    ssd_alu u_alu (
        .minuend    (minuend),
        .subtrahend (acc_r),
        .diff       (diff),
        .flags      (flags)
    );

    // opcode decode shared by the register groups
    always_comb
    begin
        is_lit  = (instr.op == SSD_OP_LIT);
        is_file = (instr.op == SSD_OP_FILE);
        to_acc  = op_to_acc(instr.op, instr.dest_sel);
        to_reg  = is_file && instr.dest_sel;
    end

    // operand source: literal from the instruction, otherwise the register file
    always_comb
    begin
        if (is_lit)
        begin
            minuend = instr.operand;
        end
        else
        begin
            minuend = file_rd_data;
        end
    end

    // index adds wrap inside the 12-bit data space
    always_comb
    begin
        amode = addr_mode(instr.operand, instr.bank_sel, ext_set_en);
        addr  = 12'h000;
        unique case (amode)
            SSD_AM_BANK:
            begin
                addr = {bank_selector, instr.operand};
            end
            SSD_AM_INDEX:
            begin
                addr = 12'(index_base + {4'h0, instr.operand});
            end
            SSD_AM_ACCESS:
            begin
                addr = access_addr(instr.operand);
            end
        endcase
    end

    // not from a flop: the register file has to answer within the cycle
    assign file_rd_addr = addr;

    // accumulator: literal form, or register form with dest 0
    always_comb
    begin
        if (to_acc)
        begin
            acc_nxt = diff;
        end
        else
        begin
            acc_nxt = acc_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            acc_r <= ACC_RESET;
        end
        else
        begin
            acc_r <= acc_nxt;
        end
    end

    // status: both forms update all five flags
    always_comb
    begin
        if (op_runs(instr.op))
        begin
            flags_nxt = flags;
        end
        else
        begin
            flags_nxt = flags_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            flags_r <= FLAGS_RESET;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // write back to the source register; en is a one-cycle pulse
    always_comb
    begin
        file_wr_nxt = '0;
        if (to_reg)
        begin
            file_wr_nxt.en   = 1'b1;
            file_wr_nxt.addr = addr;
            file_wr_nxt.data = diff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            file_wr_r <= '0;
        end
        else
        begin
            file_wr_r <= file_wr_nxt;
        end
    end

    // completion pulse, one per executed instruction
    always_comb
    begin
        done_nxt = op_runs(instr.op);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= done_nxt;
        end
    end
endmodule
